/* File: ctrl_regs_map.svh */
`ifndef CTRL_REGS_MAP_SVH
`define CTRL_REGS_MAP_SVH
// Register addresses (7-bit)
`define ADDR_WATCHDOG_CONTROL 7'h03
`define ADDR_BUS_CONTROL_ZERO 7'h04
`define ADDR_INTERNAL_WAKE_CONTROL 7'h06
`define ADDR_EXTERNAL_WAKE_CONTROL 7'h07
// Reset values on power-on or soft reset
`define RST_WATCHDOG_CONTROL 8'h14
`define RST_BUS_CONTROL_ZERO 8'h00
`define RST_INTERNAL_WAKE_CONTROL 8'h00
`define RST_EXTERNAL_WAKE_CONTROL 8'h01
// Writable bit masks (reserved bits clear)
`define MASK_WATCHDOG_CONTROL 8'hF7
`define MASK_BUS_CONTROL_ZERO 8'h07
`define MASK_INTERNAL_WAKE_CONTROL 8'h44
`define MASK_EXTERNAL_WAKE_CONTROL 8'hA1
// Restart: bits kept from before, and value forced in the others
`define KEEP_WATCHDOG_CONTROL 8'hB0
`define RSTRT_WATCHDOG_CONTROL 8'h04
`define KEEP_INTERNAL_WAKE_CONTROL 8'h40
`define KEEP_EXTERNAL_WAKE_CONTROL 8'hA1
// Field positions
`define POS_CHECKSUM 7
`define POS_STOP_DOG_OFF_LO 6
`define POS_WINDOW_TYPE 5
`define POS_DOG_START_BUS_WAKE 4
`define POS_TIMER_WAKE_EN 6
`define POS_STOP_DOG_OFF_HI 2
`define POS_IRQ_GLOBAL 7
`define POS_VOLTAGE_SENSE 5
`define POS_PIN_WAKE_EN 0
// CAN mode low-bit codes
`define CAN_LO_OFF 2'h0
`define CAN_LO_WAKE 2'h1
`define CAN_LO_RXONLY 2'h2
`define CAN_LO_NORMAL 2'h3
// Development-mode reset value of the CAN field
`define CAN_DEV_RESET 3'h3
`endif

/* File: ctrl_regs_pkg.sv */
package ctrl_regs_pkg;
  // Transceiver modes decoded from the low two CAN bits
  typedef enum logic [1:0] {
    CAN_OFF, CAN_WAKE, CAN_RXONLY, CAN_NORMAL
  } can_mode_t;
  // Device mode change events seen by this register slice
  typedef enum logic [2:0] {
    EV_NONE, EV_SLEEP, EV_STOP, EV_STOP_TO_NORMAL, EV_FAILSAFE, EV_RESTART
  } mode_event_t;
endpackage : ctrl_regs_pkg

/* File: ctrl_regs_if.sv */
`timescale 1ns/1ps
// Carries the register bytes from the bank into the decode module and the decoded fields back
interface ctrl_regs_if;
  logic [7:0] wd_q;
  logic [7:0] bus_q;
  logic [7:0] iwk_q;
  logic [7:0] ewk_q;
  logic stop_dog_off_lo;
  logic stop_dog_off_hi;
  logic window_type_select;
  logic dog_start_on_bus_wake;
  logic [2:0] dog_period_field;
  logic [2:0] can_mode;
  logic selective_wake;
  logic cyclic_timer_wake_enable;
  logic irq_global;
  logic pin_voltage_sense_select;
  logic pin_wake_enable;
  logic checksum_ok;
  modport bank (output wd_q, output bus_q, output iwk_q, output ewk_q,
    input stop_dog_off_lo, input stop_dog_off_hi, input window_type_select,
    input dog_start_on_bus_wake, input dog_period_field, input can_mode,
    input selective_wake, input cyclic_timer_wake_enable, input irq_global,
    input pin_voltage_sense_select, input pin_wake_enable,
    input checksum_ok);
  modport decode (input wd_q, input bus_q, input iwk_q, input ewk_q,
    output stop_dog_off_lo, output stop_dog_off_hi,
    output window_type_select, output dog_start_on_bus_wake,
    output dog_period_field, output can_mode, output selective_wake,
    output cyclic_timer_wake_enable, output irq_global,
    output pin_voltage_sense_select, output pin_wake_enable,
    output checksum_ok);
endinterface : ctrl_regs_if

/* File: ctrl_field_decode.sv */
`timescale 1ns/1ps
`include "ctrl_regs_map.svh"
// Splits the stored register bytes into named control fields
module ctrl_field_decode (
  ctrl_regs_if.decode f
);
  // Watchdog fields
  assign f.stop_dog_off_lo = f.wd_q[`POS_STOP_DOG_OFF_LO];
  assign f.window_type_select = f.wd_q[`POS_WINDOW_TYPE];
  assign f.dog_start_on_bus_wake = f.wd_q[`POS_DOG_START_BUS_WAKE];
  assign f.dog_period_field = f.wd_q[2:0];
  // Even parity across the whole byte means the checksum is good
  assign f.checksum_ok = ~(^f.wd_q);
  // CAN mode and its selective-wake bit
  assign f.can_mode = f.bus_q[2:0];
  assign f.selective_wake = f.bus_q[2];
  // Wake control fields
  assign f.cyclic_timer_wake_enable = f.iwk_q[`POS_TIMER_WAKE_EN];
  assign f.stop_dog_off_hi = f.iwk_q[`POS_STOP_DOG_OFF_HI];
  assign f.irq_global = f.ewk_q[`POS_IRQ_GLOBAL];
  assign f.pin_voltage_sense_select = f.ewk_q[`POS_VOLTAGE_SENSE];
  // Voltage sensing suppresses every wake from the pin
  assign f.pin_wake_enable = f.ewk_q[`POS_PIN_WAKE_EN] &
                             ~f.ewk_q[`POS_VOLTAGE_SENSE];
endmodule : ctrl_field_decode

/* File: watchdog_wake_can_ctrl_regs.sv */
`timescale 1ns/1ps
`include "ctrl_regs_map.svh"
// Summary of operation
// - Bit 6 turns watchdog off in Stop.
// - Bit 5 selects window or time-out watchdog.
// - Bit 4 starts watchdog after CAN wake.
// - Reserved bits always read back zero.
// - Watchdog resets 0x14; restart applies x0xx0100.
// - CAN field: off, wake, receive, normal, selective.
// - Hardware never changes the selective-wake bit.
// - Sleep without error turns normal into wake.
// - Receive-only: Sleep gives wake, Stop keeps it.
// - Wake-capable or off stays unchanged on entry.
// - Fail-Safe forces bus control to 0000 0x01.
// - Development mode resets CAN field to normal.
// - Restart clears bus upper bits, mode varies.
// - Internal wake bit 6 enables timer wake.
// - Internal wake bit 2 turns watchdog off.
// - Stop to Normal clears second watchdog-off bit.
// - Internal wake resets zero; restart keeps bit 6.
// - External bit 7 widens interrupt output scope.
// - External bit 5 selects sensing, blocks pin wake.
// - External wake resets 0x01; restart keeps x bits.
// - Fail-Safe without sensing re-enables pin wake.
module watchdog_wake_can_ctrl_regs (
  input wire logic clock,
  input wire logic resetn,
  input wire logic soft_reset,
  input wire logic development_mode,
  input wire logic system_error_flag,
  input wire ctrl_regs_pkg::mode_event_t mode_event,
  input wire logic [2:0] restart_can_mode,
  input wire logic [6:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic stop_dog_off_lo,
  output logic stop_dog_off_hi,
  output logic window_type_select,
  output logic dog_start_on_bus_wake,
  output logic [2:0] dog_period_field,
  output logic watchdog_checksum_ok,
  output logic [2:0] can_mode,
  output logic selective_wake,
  output logic cyclic_timer_wake_enable,
  output logic irq_global,
  output logic pin_voltage_sense_select,
  output logic pin_wake_enable
);
  // All bank state held in one packed struct
  typedef struct packed {
    logic [7:0] wd;
    logic [7:0] bus;
    logic [7:0] iwk;
    logic [7:0] ewk;
    logic dev_seen;
  } state_t;

  state_t state_q; // Registered state
  state_t state_d; // Next state
  ctrl_regs_if fields (); // Decoded fields
  ctrl_regs_pkg::can_mode_t low_mode; // Current transceiver mode

  assign fields.wd_q = state_q.wd;
  assign fields.bus_q = state_q.bus;
  assign fields.iwk_q = state_q.iwk;
  assign fields.ewk_q = state_q.ewk;

  // Field decode lives in its own module so the bank stays readable
  ctrl_field_decode u_decode (
    .f(fields)
  );

  assign low_mode = ctrl_regs_pkg::can_mode_t'(state_q.bus[1:0]);

  // Next-state: software write first, then hardware events override
  always_comb begin
    state_d = state_q;
    // Development strap is taken once after reset release
    if (!state_q.dev_seen) begin
      state_d.dev_seen = 1'b1;
      if (development_mode) begin
        state_d.bus = {5'h00, `CAN_DEV_RESET};
      end
    end
    // Software write, masked so reserved bits stay zero
    if (reg_write) begin
      case (reg_addr)
        `ADDR_WATCHDOG_CONTROL: begin
          state_d.wd = reg_wdata & `MASK_WATCHDOG_CONTROL;
        end
        `ADDR_BUS_CONTROL_ZERO: begin
          state_d.bus = reg_wdata & `MASK_BUS_CONTROL_ZERO;
        end
        `ADDR_INTERNAL_WAKE_CONTROL: begin
          state_d.iwk = reg_wdata & `MASK_INTERNAL_WAKE_CONTROL;
        end
        `ADDR_EXTERNAL_WAKE_CONTROL: begin
          state_d.ewk = reg_wdata & `MASK_EXTERNAL_WAKE_CONTROL;
        end
        default: begin
          // Writes elsewhere belong to other banks
        end
      endcase
    end
    // Hardware events act on the current value and win over a write; Stop to Normal only clears its bit in the new value
    case (mode_event)
      ctrl_regs_pkg::EV_SLEEP: begin
        // Error-free normal or receive-only both fall back to wake capable
        if ((low_mode == ctrl_regs_pkg::CAN_NORMAL && !system_error_flag)
            || low_mode == ctrl_regs_pkg::CAN_RXONLY) begin
          state_d.bus = {5'h00, state_q.bus[2], `CAN_LO_WAKE};
        end else begin
          // Off and wake capable are kept, as is an erroneous normal
          state_d.bus = state_q.bus;
        end
      end
      ctrl_regs_pkg::EV_STOP: begin
        // Receive-only stays; nothing else is touched either
        state_d.bus = state_q.bus;
      end
      ctrl_regs_pkg::EV_STOP_TO_NORMAL: begin
        state_d.iwk[`POS_STOP_DOG_OFF_HI] = 1'b0;
      end
      ctrl_regs_pkg::EV_FAILSAFE: begin
        // Selective-wake bit is never altered by hardware
        state_d.bus = {5'h00, state_q.bus[2], `CAN_LO_WAKE};
        if (!state_q.ewk[`POS_VOLTAGE_SENSE]) begin
          state_d.ewk = (state_q.ewk & 8'hA0) | 8'h01;
        end
      end
      ctrl_regs_pkg::EV_RESTART: begin
        state_d.wd = (state_q.wd & `KEEP_WATCHDOG_CONTROL)
                     | `RSTRT_WATCHDOG_CONTROL;
        // Low mode bits come from the cause; top bit is software-owned
        state_d.bus = {5'h00, state_q.bus[2],
                       restart_can_mode[1:0]};
        state_d.iwk = state_q.iwk & `KEEP_INTERNAL_WAKE_CONTROL;
        state_d.ewk = state_q.ewk & `KEEP_EXTERNAL_WAKE_CONTROL;
      end
      default: begin
        // No mode change this cycle
      end
    endcase
    // Soft reset beats everything and re-reads the strap
    if (soft_reset) begin
      state_d.wd = `RST_WATCHDOG_CONTROL;
      state_d.bus = `RST_BUS_CONTROL_ZERO;
      state_d.iwk = `RST_INTERNAL_WAKE_CONTROL;
      state_d.ewk = `RST_EXTERNAL_WAKE_CONTROL;
      state_d.dev_seen = 1'b0;
    end
  end

  // State register; asynchronous reset loads constants only
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q.wd <= `RST_WATCHDOG_CONTROL;
      state_q.bus <= `RST_BUS_CONTROL_ZERO;
      state_q.iwk <= `RST_INTERNAL_WAKE_CONTROL;
      state_q.ewk <= `RST_EXTERNAL_WAKE_CONTROL;
      state_q.dev_seen <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // Readback is combinational from stored state; reserved bits are zero
  always_comb begin
    case (reg_addr)
      `ADDR_WATCHDOG_CONTROL: reg_rdata = state_q.wd;
      `ADDR_BUS_CONTROL_ZERO: reg_rdata = state_q.bus;
      `ADDR_INTERNAL_WAKE_CONTROL: reg_rdata = state_q.iwk;
      `ADDR_EXTERNAL_WAKE_CONTROL: reg_rdata = state_q.ewk;
      default: reg_rdata = 8'h00;
    endcase
  end

  // Field outputs, all derived from flip-flops
  assign stop_dog_off_lo = fields.stop_dog_off_lo;
  assign stop_dog_off_hi = fields.stop_dog_off_hi;
  assign window_type_select = fields.window_type_select;
  assign dog_start_on_bus_wake = fields.dog_start_on_bus_wake;
  assign dog_period_field = fields.dog_period_field;
  assign watchdog_checksum_ok = fields.checksum_ok;
  assign can_mode = fields.can_mode;
  assign selective_wake = fields.selective_wake;
  assign cyclic_timer_wake_enable = fields.cyclic_timer_wake_enable;
  assign irq_global = fields.irq_global;
  assign pin_voltage_sense_select = fields.pin_voltage_sense_select;
  assign pin_wake_enable = fields.pin_wake_enable;
endmodule : watchdog_wake_can_ctrl_regs

/* File: watchdog_wake_can_ctrl_regs_assertions.sv */
`timescale 1ns/1ps
// Port-level checks of the register slice; sees only top ports
module watchdog_wake_can_ctrl_regs_assertions (
  input wire logic clock,
  input wire logic resetn,
  input wire logic soft_reset,
  input wire logic system_error_flag,
  input wire ctrl_regs_pkg::mode_event_t mode_event,
  input wire logic [2:0] restart_can_mode,
  input wire logic [6:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic stop_dog_off_lo,
  input wire logic stop_dog_off_hi,
  input wire logic [2:0] dog_period_field,
  input wire logic [2:0] can_mode,
  input wire logic pin_voltage_sense_select,
  input wire logic pin_wake_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_rsvd; reg_addr == 7'h04 |-> reg_rdata[7:3] == 5'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("bus reserved bits set");
  property p_sleep; mode_event == ctrl_regs_pkg::EV_SLEEP && !soft_reset &&
    !system_error_flag && can_mode[1:0] == 2'h3 |=>
    can_mode == {$past(can_mode[2]), 2'h1}; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep kept normal");
  property p_stop; mode_event == ctrl_regs_pkg::EV_STOP && !soft_reset |=>
    $stable(can_mode); endproperty
  a_stop: assert property (p_stop) else $error("stop changed can mode");
  property p_swk; !soft_reset && mode_event != ctrl_regs_pkg::EV_RESTART &&
    !(reg_write && reg_addr == 7'h04) |=> $stable(can_mode[2]); endproperty
  a_swk: assert property (p_swk) else $error("top can bit moved");
  property p_fsafe; mode_event == ctrl_regs_pkg::EV_FAILSAFE && !soft_reset
    |=> can_mode[1:0] == 2'h1 && $stable(can_mode[2]); endproperty
  a_fsafe: assert property (p_fsafe) else $error("failsafe can mode");
  property p_s2n; mode_event == ctrl_regs_pkg::EV_STOP_TO_NORMAL &&
    !soft_reset |=> !stop_dog_off_hi; endproperty
  a_s2n: assert property (p_s2n) else $error("stop bit not cleared");
  property p_soft; soft_reset |=> can_mode == 3'h0 && !stop_dog_off_lo &&
    dog_period_field == 3'h4 && pin_wake_enable; endproperty
  a_soft: assert property (p_soft) else $error("soft reset values");
  property p_rst; mode_event == ctrl_regs_pkg::EV_RESTART && !soft_reset |=>
    can_mode[1:0] == $past(restart_can_mode[1:0]) && !stop_dog_off_lo &&
    !stop_dog_off_hi && dog_period_field == 3'h4; endproperty
  a_rst: assert property (p_rst) else $error("restart values");
  property p_wr; reg_write && reg_addr == 7'h04 && !soft_reset &&
    mode_event == ctrl_regs_pkg::EV_NONE |=>
    can_mode == $past(reg_wdata[2:0]); endproperty
  a_wr: assert property (p_wr) else $error("can write lost");
  property p_sense; pin_voltage_sense_select |-> !pin_wake_enable; endproperty
  a_sense: assert property (p_sense) else $error("pin wake while sensing");
endmodule : watchdog_wake_can_ctrl_regs_assertions
bind watchdog_wake_can_ctrl_regs watchdog_wake_can_ctrl_regs_assertions u_chk (
  .clock, .resetn, .soft_reset, .system_error_flag, .mode_event,
  .restart_can_mode, .reg_addr, .reg_write, .reg_wdata, .reg_rdata,
  .stop_dog_off_lo, .stop_dog_off_hi, .dog_period_field, .can_mode,
  .pin_voltage_sense_select, .pin_wake_enable);

/* File: host_model.sv */
`timescale 1ns/1ps
// Host side: one write strobe per write request, one cycle after go
module host_model (
  input wire logic clock,
  input wire logic go,
  input wire logic wr,
  input wire logic [6:0] addr,
  input wire logic [7:0] data,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write
);
  initial reg_addr = 7'h00;
  initial reg_wdata = 8'h00;
  initial reg_write = 1'h0;
  // Data toggles when idle so a stale byte is never mistaken for a write
  always @(posedge clock) begin
    reg_write <= go & wr;
    if (go)
      reg_addr <= addr;
    if (go & wr)
      // Parity over the bits that are stored; bit 3 always reads zero
      reg_wdata <= (addr == 7'h03) ?
        {^(data[6:0] & 7'h77), data[6:0]} : data;
    else
      reg_wdata <= ~reg_wdata;
  end
endmodule : host_model

/* File: watchdog_wake_can_ctrl_regs_bench.sv */
`timescale 1ns/1ps
module watchdog_wake_can_ctrl_regs_bench;
  logic clock = 0, resetn = 0, soft_reset = 0, development_mode = 0;
  logic system_error_flag = 0, go = 0, wr = 0, reg_write, er = 0;
  logic [6:0] addr = 0, reg_addr, a;
  logic [7:0] data = 0, reg_wdata, reg_rdata, d;
  logic [2:0] restart_can_mode = 0, rc = 0, cm;
  logic csum;
  ctrl_regs_pkg::mode_event_t mode_event = ctrl_regs_pkg::EV_NONE;
  int error_cnt = 0, tests_run = 0;
  initial forever #2.5 clock = ~clock;
  host_model host (.clock, .go, .wr, .addr, .data, .reg_addr, .reg_wdata,
    .reg_write);
  watchdog_wake_can_ctrl_regs dut (.clock, .resetn, .soft_reset,
    .development_mode, .system_error_flag, .mode_event, .restart_can_mode,
    .reg_addr, .reg_write, .reg_wdata, .reg_rdata, .stop_dog_off_lo(),
    .stop_dog_off_hi(), .window_type_select(), .dog_start_on_bus_wake(),
    .dog_period_field(), .watchdog_checksum_ok(csum), .can_mode(cm),
    .selective_wake(), .cyclic_timer_wake_enable(), .irq_global(),
    .pin_voltage_sense_select(), .pin_wake_enable());
  // Readback of a write: host parity fix, then reserved bits dropped
  function automatic logic [7:0] exp_wr(logic [6:0] x, logic [7:0] y);
    case (x)
      7'h03: return {^(y[6:0] & 7'h77), y[6:0]} & 8'hF7;
      7'h04: return y & 8'h07;
      7'h06: return y & 8'h44;
      7'h07: return y & 8'hA1;
      default: return 8'h00;
    endcase
  endfunction : exp_wr
  // Bus byte after an event; the top mode bit is always carried over
  function automatic logic [7:0] exp_bus(logic [2:0] v, int e);
    logic [1:0] lo;
    lo = v[1:0];
    if (e == 1 && v[1] && !(v[0] && er))
      lo = 2'h1;
    if (e == 4)
      lo = 2'h1;
    if (e == 5)
      lo = rc[1:0];
    return {5'h00, v[2], lo};
  endfunction : exp_bus
  task check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task wreg(input logic [6:0] x, input logic [7:0] y);
    @(posedge clock);
    go <= 1'h1;
    wr <= 1'h1;
    addr <= x;
    data <= y;
    @(posedge clock);
    go <= 1'h0;
    @(posedge clock);
  endtask : wreg
  task rchk(input logic [6:0] x, input logic [7:0] exp);
    @(posedge clock);
    go <= 1'h1;
    wr <= 1'h0;
    addr <= x;
    @(posedge clock);
    go <= 1'h0;
    @(posedge clock);
    #1 check(reg_rdata, exp);
  endtask : rchk
  // Event code is a one-cycle pulse, qualifiers launched with it
  task ev(input int e);
    @(posedge clock);
    mode_event <= ctrl_regs_pkg::mode_event_t'(e);
    system_error_flag <= er;
    restart_can_mode <= rc;
    @(posedge clock);
    mode_event <= ctrl_regs_pkg::EV_NONE;
  endtask : ev
  task results;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results
  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    results();
  end
  initial begin
    void'($urandom(8953));
    repeat (2) @(posedge clock);
    resetn <= 1'h1;
    rchk(7'h03, 8'h14);
    rchk(7'h04, 8'h00);
    rchk(7'h06, 8'h00);
    rchk(7'h07, 8'h01);
    $display("reset values done");
    // Address 05 is unmapped and must read zero
    repeat (16) begin
      a = 7'($urandom % 5 + 3);
      d = 8'($urandom);
      wreg(a, d);
      rchk(a, exp_wr(a, d));
      check({7'h00, csum}, 8'h01);
    end
    $display("random writes done");
    for (int v = 0; v < 8; v++) begin
      for (int e = 1; e < 6; e++) begin
        d = 8'($urandom);
        rc = 3'($urandom);
        er = 1'(v >> 2); // Error flag set only with the top mode bit
        wreg(7'h04, 8'(v));
        wreg(7'h07, d);
        ev(e);
        rchk(7'h04, exp_bus(3'(v), e));
        check({5'h00, cm}, exp_bus(3'(v), e));
        rchk(7'h07, (e == 4 && !d[5]) ? ((d & 8'hA0) | 8'h01) : (d & 8'hA1));
      end
    end
    $display("mode events done");
    wreg(7'h06, 8'hFF);
    ev(3);
    rchk(7'h06, 8'h40);
    wreg(7'h03, 8'hFF);
    wreg(7'h06, 8'hFF);
    ev(5);
    rchk(7'h03, 8'h34);
    rchk(7'h06, 8'h40);
    $display("restart done");
    @(posedge clock);
    development_mode <= 1'h1;
    soft_reset <= 1'h1;
    @(posedge clock);
    soft_reset <= 1'h0;
    rchk(7'h03, 8'h14);
    rchk(7'h04, 8'h03);
    rchk(7'h07, 8'h01);
    $display("soft reset done");
    results();
  end
endmodule : watchdog_wake_can_ctrl_regs_bench
